// [rtl/cspc_pkg.sv]
package cspc_pkg;

  // Clock rate and the time units that the timers count in.
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned US_PER_S = 1_000_000;
  localparam int unsigned VIN_RESP_US = 100;
  localparam int unsigned SYNC_LAT = 3;

  // Command codes of the register map.
  localparam logic [7:0] C_ON_OFF = 8'h02;
  localparam logic [7:0] C_VOUT_TGT = 8'h21;
  localparam logic [7:0] C_VOUT_TRIM = 8'h22;
  localparam logic [7:0] C_OC_LIM = 8'h46;
  localparam logic [7:0] C_OT_FLT = 8'h4f;
  localparam logic [7:0] C_OT_WARN = 8'h51;
  localparam logic [7:0] C_PG_ON = 8'h5e;
  localparam logic [7:0] C_PG_OFF = 8'h5f;
  localparam logic [7:0] C_TON_DLY = 8'h60;
  localparam logic [7:0] C_TURN_ON_RISE_TIME = 8'h61;
  localparam logic [7:0] C_TOFF_DLY = 8'h64;
  localparam logic [7:0] C_TURN_OFF_FALL_TIME = 8'h65;
  localparam logic [7:0] C_TOFF_MAX = 8'h66;
  localparam logic [7:0] C_TEMP = 8'h8d;
  localparam logic [7:0] C_PG_POL = 8'hd0;
  localparam logic [7:0] C_ADDR_OFS = 8'hee;
  localparam logic [7:0] C_PIN_SEL = 8'hf9;
  localparam logic [7:0] C_FSW = 8'he0;
  localparam logic [7:0] C_OPERATION = 8'he1;
  localparam logic [7:0] C_STATUS = 8'he2;
  localparam logic [7:0] C_UT_FLT = 8'he3;

  // Bit positions inside the control registers.
  localparam int unsigned B_SOFTSTOP = 0;
  localparam int unsigned B_CTRL_EN = 1;
  localparam int unsigned B_CTRL_POL = 2;
  localparam int unsigned B_OP_ON = 0;
  localparam int unsigned B_MHI = 1;
  localparam int unsigned B_MLO = 2;
  localparam int unsigned B_PIN_OD = 1;
  localparam int unsigned B_POL_HIGH = 0;

  // Reset values of the registers, the parallel pin setting and the switching-frequency limits.
  localparam logic [7:0] RST_ON_OFF = 8'h00;
  localparam logic [7:0] RST_OPERATION = 8'h01;
  localparam logic [15:0] RST_VOUT_TGT = 16'h2ee0;
  localparam logic [15:0] RST_OC_LIM = 16'h0080;
  localparam logic [15:0] RST_OT_FLT = 16'h0078;
  localparam logic [15:0] RST_OT_WARN = 16'h006e;
  localparam logic [15:0] RST_PG_ON = 16'h1f40;
  localparam logic [15:0] RST_PG_OFF = 16'h1388;
  localparam logic [15:0] RST_TURN_ON_RISE_TIME = 16'h000a;
  localparam logic [15:0] RST_TURN_OFF_FALL_TIME = 16'h000a;
  localparam logic [15:0] RST_TOFF_MAX = 16'h000a;
  localparam logic [7:0] RST_PG_POL = 8'h00;
  localparam logic [7:0] RST_PIN_SEL = 8'h04;
  localparam logic [7:0] PIN_SEL_PAR = 8'h06;
  localparam logic [15:0] RST_FSW = 16'h00b4;
  localparam logic [15:0] FSW_MIN = 16'h0096;
  localparam logic [15:0] FSW_MAX = 16'h00e6;

  // Sequencing times in milliseconds, output scaling in percent and the good-band shift.
  localparam logic [15:0] BOOT_MS = 16'h001e;
  localparam logic [15:0] PAR_TON_MS = 16'h00c8;
  localparam int unsigned MARGIN_PCT = 10;
  localparam int unsigned OVP_PCT = 17;
  localparam int unsigned PCT_FULL = 100;
  localparam int unsigned TOL_SHIFT = 4;

  typedef enum logic [2:0] {
    S_BOOT, S_OFF, S_TON_DLY, S_RISE, S_REG, S_TOFF_DLY, S_FALL, S_FAULT
  } cspc_state_t;

  typedef struct packed {
    logic [5:0] rsvd;
    cspc_state_t state;
    logic run;
    logic vin;
    logic ut;
    logic ot;
    logic oc;
    logic ov;
    logic good;
  } cspc_status_t;

  typedef struct packed {
    cspc_state_t state;
    logic [31:0] pre;
    logic [15:0] tmr, sink_ms, vref, step;
    logic dir_dn, sinking, good, boot_pend, pg_out, pg_oe;
    logic [7:0] on_off, op, pgpol, aofs, pinsel;
    logic [15:0] vtgt, trim, oc, otf, otw, utf, pgon, pgoff;
    logic [15:0] tond, tonr, toffd, toffr, toffmax, fsw, rdata;
    logic [2:0] req_s;
    logic [1:0] ctrl_s, vov_s, vuv_s;
    logic ack_t;
  } cspc_sys_t;

  typedef struct packed {
    logic req_t, busy, done, we;
    logic [2:0] ack_s;
    logic [7:0] code;
    logic [15:0] wdata, rdata;
  } cspc_lnk_t;

endpackage

// [rtl/cspc_ctrl.sv]
`timescale 1ns/1ps
module cspc_ctrl
  import cspc_pkg::*;
#(
  parameter int unsigned MS_CYCLES = CLK_HZ / MS_PER_S,
  parameter logic [15:0] VOUT_MAX = 16'h3390,
  parameter logic [15:0] VOUT_MIN = 16'h2a30
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic clk_link_i,
  input wire logic lnk_req_i,
  input wire logic lnk_we_i,
  input wire logic [7:0] lnk_code_i,
  input wire logic [15:0] lnk_wdata_i,
  output logic lnk_busy_o,
  output logic lnk_done_o,
  output logic [15:0] lnk_rdata_o,
  input wire logic [15:0] vout_meas_i,
  input wire logic [15:0] iout_meas_i,
  input wire logic [15:0] temp_meas_i,
  input wire logic vin_ov_i,
  input wire logic vin_uv_i,
  input wire logic ctrl_pin_i,
  output logic regulate_o,
  output logic sink_en_o,
  output logic [15:0] vref_o,
  output logic [15:0] fsw_khz_o,
  output logic pg_o,
  output logic pg_oe_o
);

  localparam int unsigned VIN_RESP_CYC = VIN_RESP_US * (CLK_HZ / US_PER_S);

  // Refuse settings that the timers or fault path cannot serve.
  if (MS_CYCLES < 2 || VIN_RESP_CYC < SYNC_LAT) begin : g_bad_param
    $error("cspc_ctrl: timer or response settings out of range");
  end
  if (VOUT_MIN > VOUT_MAX) begin : g_bad_limits
    $error("cspc_ctrl: output limits reversed");
  end

  cspc_sys_t s_q, s_d;
  cspc_lnk_t l_q, l_d;
  cspc_status_t stat;
  logic [1:0] lrst_s;
  logic [15:0] nom, mrg, mhi, mlo, tgt, ton_ms, dv, rd_mux, err;
  logic [16:0] mhi_w;
  logic [31:0] ovp_lvl;
  logic ms_tick, flt_ov, flt_oc, flt_ot, flt_ut, flt_vin, any_flt;
  logic start_ok, en, active, req_new;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  // Setpoint arithmetic: nominal, margins and the over-voltage level.
  always_comb begin
    nom = s_q.vtgt + s_q.trim;
    mrg = 16'((32'(nom) * MARGIN_PCT) / PCT_FULL);
    mhi_w = {1'b0, nom} + {1'b0, mrg};
    mhi = (mhi_w > {1'b0, VOUT_MAX}) ? VOUT_MAX : mhi_w[15:0];
    mlo = ((nom - mrg) < VOUT_MIN) ? VOUT_MIN : nom - mrg;
    if (s_q.op[B_MHI]) begin
      tgt = mhi;
    end else if (s_q.op[B_MLO]) begin
      tgt = mlo;
    end else begin
      tgt = nom;
    end
    ovp_lvl = 32'(nom) + (32'(nom) * OVP_PCT) / PCT_FULL;
  end

  // Fault detection and the start permission.
  always_comb begin
    flt_ov = 32'(vout_meas_i) > ovp_lvl;
    flt_oc = iout_meas_i > s_q.oc;
    flt_ot = temp_meas_i >= s_q.otf;
    flt_ut = temp_meas_i < s_q.utf;
    flt_vin = s_q.vov_s[1] | s_q.vuv_s[1];
    any_flt = flt_ov | flt_oc | flt_ot | flt_ut | flt_vin;
    start_ok = !any_flt && (temp_meas_i < s_q.otw);
    en = s_q.op[B_OP_ON] && (!s_q.on_off[B_CTRL_EN] ||
         (s_q.ctrl_s[1] == s_q.on_off[B_CTRL_POL]));
    active = (s_q.state != S_BOOT) && (s_q.state != S_OFF) &&
             (s_q.state != S_FAULT);
    ton_ms = (s_q.pinsel == PIN_SEL_PAR) ? PAR_TON_MS : s_q.tond;
    ms_tick = s_q.pre == MS_CYCLES - 1;
    req_new = s_q.req_s[2] ^ s_q.req_s[1];
    err = (vout_meas_i > s_q.vref) ? vout_meas_i - s_q.vref :
          s_q.vref - vout_meas_i;
    dv = (tgt > vout_meas_i) ? tgt - vout_meas_i : vout_meas_i - tgt;
  end

  // Status word layout.
  always_comb begin
    stat = '0;
    stat.state = s_q.state;
    stat.run = s_q.state != S_FAULT && active;
    stat.vin = flt_vin;
    stat.ut = flt_ut;
    stat.ot = flt_ot;
    stat.oc = flt_oc;
    stat.ov = flt_ov;
    stat.good = s_q.good && !any_flt && s_q.state == S_REG &&
                (err <= (s_q.vref >> TOL_SHIFT));
  end

  // Read multiplexer; unmapped codes read as zero.
  always_comb begin
    case (l_q.code)
      C_ON_OFF: rd_mux = {8'h00, s_q.on_off};
      C_VOUT_TGT: rd_mux = s_q.vtgt;
      C_VOUT_TRIM: rd_mux = s_q.trim;
      C_OC_LIM: rd_mux = s_q.oc;
      C_OT_FLT: rd_mux = s_q.otf;
      C_OT_WARN: rd_mux = s_q.otw;
      C_PG_ON: rd_mux = s_q.pgon;
      C_PG_OFF: rd_mux = s_q.pgoff;
      C_TON_DLY: rd_mux = s_q.tond;
      C_TURN_ON_RISE_TIME: rd_mux = s_q.tonr;
      C_TOFF_DLY: rd_mux = s_q.toffd;
      C_TURN_OFF_FALL_TIME: rd_mux = s_q.toffr;
      C_TOFF_MAX: rd_mux = s_q.toffmax;
      C_TEMP: rd_mux = temp_meas_i;
      C_PG_POL: rd_mux = {8'h00, s_q.pgpol};
      C_ADDR_OFS: rd_mux = {8'h00, s_q.aofs};
      C_PIN_SEL: rd_mux = {8'h00, s_q.pinsel};
      C_FSW: rd_mux = s_q.fsw;
      C_OPERATION: rd_mux = {8'h00, s_q.op};
      C_STATUS: rd_mux = stat;
      C_UT_FLT: rd_mux = s_q.utf;
      default: rd_mux = 16'h0000;
    endcase
  end

  // System-domain next state: register access, sequencer, power-good.
  always_comb begin
    s_d = s_q;
    if (ce_i) begin
      s_d.pre = ms_tick ? 32'h0 : s_q.pre + 32'h1;
      if (ms_tick && s_q.tmr != 16'hffff) begin
        s_d.tmr = s_q.tmr + 16'h1;
      end
      s_d.req_s = {s_q.req_s[1:0], l_q.req_t};
      s_d.ctrl_s = {s_q.ctrl_s[0], ctrl_pin_i};
      s_d.vov_s = {s_q.vov_s[0], vin_ov_i};
      s_d.vuv_s = {s_q.vuv_s[0], vin_uv_i};
      // A request seen on the link is served once and acknowledged.
      if (req_new) begin
        s_d.ack_t = !s_q.ack_t;
        s_d.rdata = rd_mux;
        if (l_q.we) begin
          case (l_q.code)
            C_ON_OFF: s_d.on_off = l_q.wdata[7:0];
            C_VOUT_TGT: s_d.vtgt = l_q.wdata;
            C_VOUT_TRIM: s_d.trim = l_q.wdata;
            C_OC_LIM: s_d.oc = l_q.wdata;
            C_OT_FLT: s_d.otf = l_q.wdata;
            C_OT_WARN: s_d.otw = l_q.wdata;
            C_PG_ON: s_d.pgon = l_q.wdata;
            C_PG_OFF: s_d.pgoff = l_q.wdata;
            C_TON_DLY: s_d.tond = l_q.wdata;
            C_TURN_ON_RISE_TIME: s_d.tonr = l_q.wdata;
            C_TOFF_DLY: s_d.toffd = l_q.wdata;
            C_TURN_OFF_FALL_TIME: s_d.toffr = l_q.wdata;
            C_TOFF_MAX: s_d.toffmax = l_q.wdata;
            C_PG_POL: s_d.pgpol = l_q.wdata[7:0];
            C_ADDR_OFS: s_d.aofs = l_q.wdata[7:0];
            C_PIN_SEL: s_d.pinsel = l_q.wdata[7:0];
            C_OPERATION: s_d.op = l_q.wdata[7:0];
            C_UT_FLT: s_d.utf = l_q.wdata;
            C_FSW: begin
              if (l_q.wdata >= FSW_MIN && l_q.wdata <= FSW_MAX) begin
                s_d.fsw = l_q.wdata;
              end
            end
            default: begin
            end
          endcase
        end
      end
      // Sinking into a high pre-bias is allowed for a bounded time.
      if (s_q.sinking && ms_tick) begin
        s_d.sink_ms = s_q.sink_ms + 16'h1;
        if (s_q.sink_ms + 16'h1 >= s_q.toffmax) begin
          s_d.sinking = 1'b0;
        end
      end
      case (s_q.state)
        S_BOOT: begin
          s_d.vref = 16'h0000;
          if (s_q.tmr >= BOOT_MS) begin
            s_d.state = S_OFF;
          end
        end
        S_OFF: begin
          s_d.vref = 16'h0000;
          if (en && start_ok) begin
            s_d.state = S_TON_DLY;
          end
        end
        S_TON_DLY: begin
          if (!en) begin
            s_d.state = S_OFF;
          end else if (s_q.tmr >= ton_ms) begin
            // The ramp starts from whatever the output already holds.
            s_d.state = S_RISE;
            s_d.vref = vout_meas_i;
            s_d.dir_dn = vout_meas_i > tgt;
            s_d.sinking = vout_meas_i > tgt;
            s_d.sink_ms = 16'h0000;
            s_d.step = dv / ((s_q.tonr == 16'h0) ? 16'h1 : s_q.tonr);
          end
        end
        S_RISE: begin
          if (!en) begin
            s_d.state = s_q.on_off[B_SOFTSTOP] ? S_TOFF_DLY : S_OFF;
            s_d.sinking = 1'b0;
            if (!s_q.on_off[B_SOFTSTOP]) begin
              s_d.vref = 16'h0000;
            end
          end else if (s_q.tmr >= s_q.tonr) begin
            s_d.state = S_REG;
            s_d.vref = tgt;
          end else if (ms_tick && !s_q.dir_dn) begin
            s_d.vref = (tgt - s_q.vref > s_q.step) ?
                       s_q.vref + s_q.step : tgt;
          end else if (ms_tick && s_q.sinking) begin
            s_d.vref = (s_q.vref - tgt > s_q.step) ?
                       s_q.vref - s_q.step : tgt;
          end
        end
        S_REG: begin
          s_d.vref = tgt;
          if (!en) begin
            s_d.sinking = 1'b0;
            if (s_q.on_off[B_SOFTSTOP]) begin
              s_d.state = S_TOFF_DLY;
            end else begin
              s_d.state = S_OFF;
              s_d.vref = 16'h0000;
            end
          end
        end
        S_TOFF_DLY: begin
          if (s_q.tmr >= s_q.toffd) begin
            s_d.state = S_FALL;
            s_d.step = s_q.vref /
                       ((s_q.toffr == 16'h0) ? 16'h1 : s_q.toffr);
          end
        end
        S_FALL: begin
          if (s_q.tmr >= s_q.toffr) begin
            s_d.state = S_OFF;
            s_d.vref = 16'h0000;
          end else if (ms_tick) begin
            s_d.vref = (s_q.vref > s_q.step) ?
                       s_q.vref - s_q.step : 16'h0000;
          end
        end
        S_FAULT: begin
          s_d.vref = 16'h0000;
          // Keep retrying; leave only once every start check passes.
          if (start_ok) begin
            s_d.state = s_q.boot_pend ? S_BOOT : S_OFF;
          end
        end
        default: s_d.state = S_FAULT;
      endcase
      // Any fault while running stops regulation at once.
      if (active && any_flt) begin
        s_d.state = S_FAULT;
        s_d.vref = 16'h0000;
        s_d.sinking = 1'b0;
        s_d.boot_pend = s_q.vuv_s[1];
      end else if (s_q.state == S_BOOT) begin
        s_d.boot_pend = 1'b0;
      end
      // Power-good: on above one threshold, off below the other.
      if (s_q.state != S_REG || any_flt) begin
        s_d.good = 1'b0;
      end else if (vout_meas_i > s_q.pgon) begin
        s_d.good = 1'b1;
      end else if (vout_meas_i < s_q.pgoff) begin
        s_d.good = 1'b0;
      end
      s_d.pg_out = s_d.pgpol[B_POL_HIGH] ? s_d.good : !s_d.good;
      if (s_d.pinsel[B_PIN_OD]) begin
        s_d.pg_oe = !s_d.pg_out;
        s_d.pg_out = 1'b0;
      end else begin
        s_d.pg_oe = 1'b1;
      end
      // Each state's timer starts from a whole millisecond.
      if (s_d.state != s_q.state) begin
        s_d.tmr = 16'h0000;
        s_d.pre = 32'h0;
      end
    end
  end

  // System-domain register; reset starts in the boot interval.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.on_off <= RST_ON_OFF;
      s_q.op <= RST_OPERATION;
      s_q.vtgt <= RST_VOUT_TGT;
      s_q.oc <= RST_OC_LIM;
      s_q.otf <= RST_OT_FLT;
      s_q.otw <= RST_OT_WARN;
      s_q.pgon <= RST_PG_ON;
      s_q.pgoff <= RST_PG_OFF;
      s_q.tonr <= RST_TURN_ON_RISE_TIME;
      s_q.toffr <= RST_TURN_OFF_FALL_TIME;
      s_q.toffmax <= RST_TOFF_MAX;
      s_q.pgpol <= RST_PG_POL;
      s_q.pinsel <= RST_PIN_SEL;
      s_q.fsw <= RST_FSW;
      s_q.pg_out <= 1'b1;
      s_q.pg_oe <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // The link-domain reset is a synchronised copy of the system reset.
  always_ff @(posedge clk_link_i) begin
    lrst_s <= {lrst_s[0], rst_n_i};
  end

  // Link side: take a request, hold it, wait for the acknowledge.
  always_comb begin
    l_d = l_q;
    l_d.done = 1'b0;
    l_d.ack_s = {l_q.ack_s[1:0], s_q.ack_t};
    if (!l_q.busy && lnk_req_i) begin
      l_d.busy = 1'b1;
      l_d.req_t = !l_q.req_t;
      l_d.we = lnk_we_i;
      l_d.code = lnk_code_i;
      l_d.wdata = lnk_wdata_i;
    end else if (l_q.busy && (l_q.ack_s[2] ^ l_q.ack_s[1])) begin
      l_d.busy = 1'b0;
      l_d.done = 1'b1;
      l_d.rdata = s_q.rdata;
    end
  end

  always_ff @(posedge clk_link_i) begin
    if (!lrst_s[1]) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // Outputs come straight from the state registers; regulate_o is decoded from the state.
  assign lnk_busy_o = l_q.busy;
  assign lnk_done_o = l_q.done;
  assign lnk_rdata_o = l_q.rdata;
  assign regulate_o = active;
  assign sink_en_o = s_q.sinking;
  assign vref_o = s_q.vref;
  assign fsw_khz_o = s_q.fsw;
  assign pg_o = s_q.pg_out;
  assign pg_oe_o = s_q.pg_oe;

  // Checks on the sequencer, protections and power-good.
  sequence s_uv_in_reg;
    $rose(vin_uv_i) && ce_i && s_q.state == S_REG ##1 ce_i [*2];
  endsequence

  a_boot_hold: assert property (
    (s_q.state == S_BOOT && s_q.tmr < BOOT_MS && ce_i) |=>
    s_q.state == S_BOOT) else $error("boot interval cut short");
  a_start_gate: assert property (
    (s_q.state == S_OFF && ce_i && !start_ok) |=> s_q.state == S_OFF)
    else $error("start despite fault");
  a_warm_start: assert property (
    $changed(s_q.state) && s_q.state == S_TON_DLY |->
    $past(temp_meas_i) < $past(s_q.otw)) else $error("start while hot");
  a_ot_wait: assert property (
    (s_q.state == S_FAULT && temp_meas_i >= s_q.otw && ce_i) |=>
    s_q.state == S_FAULT) else $error("left fault-wait while hot");
  a_vin_resp: assert property (
    s_uv_in_reg |=> s_q.state == S_FAULT && !regulate_o)
    else $error("input fault not acted on in time");
  a_par_delay: assert property (
    (s_q.state == S_TON_DLY && s_q.pinsel == PIN_SEL_PAR && ce_i &&
     s_q.tmr < PAR_TON_MS) |=> s_q.state != S_RISE)
    else $error("parallel delay too short");
  a_hard_stop: assert property (
    (s_q.state == S_REG && !en && !s_q.on_off[B_SOFTSTOP] && ce_i &&
     !any_flt) |=> s_q.state == S_OFF && vref_o == 16'h0000)
    else $error("soft-stop off but output not stopped");
  a_ramp_good: assert property (
    (s_q.state != S_REG && ce_i) |=> !s_q.good)
    else $error("power-good during ramp or fault");
  a_pol_low: assert property (
    (s_q.good && s_q.pgpol == RST_PG_POL && !s_q.pinsel[B_PIN_OD]) |->
    !pg_o && pg_oe_o) else $error("active-low power-good wrong");
  a_od_drive: assert property (
    s_q.pinsel == PIN_SEL_PAR |-> !pg_o)
    else $error("open-drain pin driven high");
  a_sink_stop: assert property (
    sink_en_o |-> s_q.sink_ms < s_q.toffmax)
    else $error("sinking past its window");
  a_fsw_range: assert property (
    fsw_khz_o >= FSW_MIN && fsw_khz_o <= FSW_MAX)
    else $error("switching frequency out of range");
  a_flag_good: assert property (
    stat.good |-> s_q.state == S_REG && !any_flt)
    else $error("status good flag with fault");

endmodule

// [verif/cspc_load.sv]
`timescale 1ns/1ps
// Load at the output: it follows the setpoint while the loop regulates.
module cspc_load (
  input wire logic clk_sys_i,
  input wire logic regulate_i,
  input wire logic [15:0] vref_i,
  input wire logic ovp_i,
  output logic [15:0] vout_o,
  output logic [15:0] iout_o
);
  // A surge pushes the output above the guard level of the default and test setpoints.
  always_ff @(posedge clk_sys_i) begin
    if (ovp_i) begin
      vout_o <= 16'h3a98;
    end else begin
      vout_o <= regulate_i ? vref_i : 16'h0000;
    end
  end
  // The load draws a light, steady current.
  assign iout_o = 16'h0040;
endmodule

// [verif/tb.sv]
`timescale 1ns/1ps
module tb;
  import cspc_pkg::*;
  logic clk = 0, clk_lnk = 0, rst_n, req, we, output_overvoltage_guard, regulate, sink, pg, pg_oe;
  logic busy, done, vin_uv;
  logic [7:0] code;
  logic [15:0] wd, rd, rdata, temp, vout, iout, vref, fsw;
  int fails, checks_done;
  logic [7:0] ca [6] = '{C_PG_POL, C_PIN_SEL, C_VOUT_TGT, C_FSW, C_TURN_ON_RISE_TIME,
    8'h70};
  logic [15:0] ea [6] = '{16'h0000, 16'h0004, RST_VOUT_TGT, RST_FSW,
    RST_TURN_ON_RISE_TIME, 16'h0000};

  // System clock at 200 MHz.
  always #2.5 clk = ~clk;
  // Link clock, offset by 7 ns; some of its edges still line up with the system clock.
  initial begin
    #7;
    forever #16 clk_lnk = ~clk_lnk;
  end

  cspc_ctrl #(.MS_CYCLES(20)) cspc_ctrl_inst (.clk_sys_i(clk),
    .rst_n_i(rst_n), .ce_i(1'b1), .clk_link_i(clk_lnk), .lnk_req_i(req),
    .lnk_we_i(we), .lnk_code_i(code), .lnk_wdata_i(wd), .lnk_busy_o(busy),
    .lnk_done_o(done), .lnk_rdata_o(rdata), .vout_meas_i(vout),
    .iout_meas_i(iout), .temp_meas_i(temp), .vin_ov_i(1'b0),
    .vin_uv_i(vin_uv), .ctrl_pin_i(1'b0), .regulate_o(regulate),
    .sink_en_o(sink), .vref_o(vref), .fsw_khz_o(fsw), .pg_o(pg),
    .pg_oe_o(pg_oe));
  cspc_load cspc_load_inst (.clk_sys_i(clk), .regulate_i(regulate),
    .vref_i(vref), .ovp_i(output_overvoltage_guard), .vout_o(vout), .iout_o(iout));

  // Compares a result and counts it.
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One link access, held until the done pulse is seen at a link edge.
  task acc(input logic w, input logic [7:0] c, input logic [15:0] d);
    int n;
    @(posedge clk_lnk);
    #1 req = 1;
    we = w;
    code = c;
    wd = d;
    n = 0;
    do begin
      @(posedge clk_lnk);
      #1;
      n++;
    end while (done !== 1'b1 && n < 40);
    if (done !== 1'b1) begin
      fails++;
      $display("[ERR] %0t link access not answered", $time);
    end
    rd = rdata;
    #1 req = 0;
  endtask

  // Lets n system cycles pass and steps just past the edge.
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Waits a bounded time for the regulation flag to reach a level.
  task wreg(input logic v);
    int i;
    for (i = 0; i < 80 && regulate !== v; i++) begin
      @(posedge clk);
      #1;
    end
    chk({15'h0, regulate}, {15'h0, v});
  endtask

  // Prints the counts and the verdict, then ends the run.
  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Cuts a hung run short.
  initial begin
    #300us;
    fails++;
    stop_test;
  end

  // Main sequence of tests.
  initial begin
    {req, we, code, wd, output_overvoltage_guard, vin_uv, rst_n} = '0;
    temp = 16'h0019;
    fails = 0;
    checks_done = 0;
    repeat (3) @(posedge clk_lnk);
    @(posedge clk);
    #1 rst_n = 1;
    cyc(560);
    chk({15'h0, regulate}, 16'h0000);
    wreg(1'b1);
    cyc(180);
    chk({15'h0, pg}, 16'h0001);
    cyc(80);
    chk(vref, RST_VOUT_TGT);
    cyc(40);
    chk({15'h0, pg}, 16'h0000);
    acc(1'b1, 8'h70, 16'h1234);
    for (int i = 0; i < 6; i++) begin
      acc(1'b0, ca[i], 16'h0000);
      chk(rd, ea[i]);
    end
    acc(1'b0, C_STATUS, 16'h0000);
    chk(rd & 16'h0381, 16'h0201);
    acc(1'b1, C_FSW, 16'h00e6);
    acc(1'b1, C_FSW, 16'h00f0);
    chk(fsw, 16'h00e6);
    acc(1'b1, C_PG_POL, 16'h0001);
    cyc(4);
    chk({15'h0, pg}, 16'h0001);
    acc(1'b1, C_PIN_SEL, {8'h00, PIN_SEL_PAR});
    cyc(4);
    chk({15'h0, pg_oe}, 16'h0000);
    acc(1'b1, C_PG_POL, 16'h0000);
    cyc(4);
    chk({14'h0, pg_oe, pg}, 16'h0002);
    acc(1'b1, C_PIN_SEL, {8'h00, RST_PIN_SEL});
    acc(1'b1, C_OPERATION, 16'h0003);
    cyc(100);
    chk(vref, 16'h3390);
    acc(1'b1, C_OPERATION, 16'h0005);
    cyc(100);
    chk(vref, 16'h2a30);
    acc(1'b1, C_OPERATION, 16'h0001);
    acc(1'b1, C_VOUT_TGT, 16'h2af8);
    cyc(100);
    chk(vref, 16'h2af8);
    output_overvoltage_guard = 1;
    wreg(1'b0);
    cyc(1);
    output_overvoltage_guard = 0;
    wreg(1'b1);
    cyc(1);
    temp = 16'h007d;
    wreg(1'b0);
    cyc(1);
    temp = 16'h0073;
    cyc(100);
    chk({15'h0, regulate}, 16'h0000);
    temp = 16'h0019;
    wreg(1'b1);
    cyc(260);
    acc(1'b1, C_OPERATION, 16'h0000);
    wreg(1'b0);
    chk(vref, 16'h0000);
    acc(1'b1, C_ON_OFF, 16'h0001);
    acc(1'b1, C_OPERATION, 16'h0001);
    wreg(1'b1);
    cyc(260);
    acc(1'b1, C_OPERATION, 16'h0000);
    cyc(100);
    chk({15'h0, regulate}, 16'h0001);
    cyc(180);
    wreg(1'b0);
    acc(1'b1, C_OPERATION, 16'h0001);
    wreg(1'b1);
    cyc(260);
    vin_uv = 1;
    wreg(1'b0);
    chk({15'h0, sink}, 16'h0000);
    cyc(1);
    vin_uv = 0;
    cyc(560);
    chk({15'h0, regulate}, 16'h0000);
    wreg(1'b1);
    stop_test;
  end
endmodule
